//--- verilog/pcb_pkg.sv
/*
 * pcb_pkg: register indices, byte addresses, field masks and fixed codes
 * for the low configuration header of the card bridge.
 * Assumes APB with 32-bit data; each register takes one aligned word.
 */
`default_nettype none

package pcb_pkg;
	// ****************************************
	// bus geometry
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ****************************************
	// register indices and byte addresses (index times four)
	// ****************************************
	localparam logic [7:0] IDX_MAKER = 8'h00;
	localparam logic [7:0] IDX_PART = 8'h02;
	localparam logic [7:0] IDX_CMD = 8'h04;
	localparam logic [7:0] IDX_STS = 8'h06;
	localparam logic [7:0] IDX_REV = 8'h08;
	localparam logic [7:0] IDX_PROG = 8'h09;
	localparam logic [7:0] IDX_CLASS = 8'h0a;
	localparam logic [ADDR_W-1:0] ADDR_MAKER = {2'h0, IDX_MAKER, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PART = {2'h0, IDX_PART, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CMD = {2'h0, IDX_CMD, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STS = {2'h0, IDX_STS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_REV = {2'h0, IDX_REV, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PROG = {2'h0, IDX_PROG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CLASS = {2'h0, IDX_CLASS, 2'h0};

	// ****************************************
	// command word fields
	// ****************************************
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] CMD_WR_MASK = 16'h0147;
	localparam int CMD_IO_EN = 0;
	localparam int CMD_MEM_EN = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int CMD_PERR_EN = 6;
	localparam int CMD_SERR_EN = 8;
	localparam int CMD_FBB_EN = 9;
	localparam int CMD_WAIT_CTL = 7;

	// ****************************************
	// status word fields
	// ****************************************
	localparam logic [15:0] STS_RESET = 16'h0000;
	localparam logic [15:0] STS_W1C_MASK = 16'hf900;
	localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
	localparam int STS_PAR_ERR = 15;
	localparam int STS_SYS_ERR = 14;
	localparam int STS_MST_ABORT = 13;
	localparam int STS_TGT_ABORT_RCV = 12;
	localparam int STS_TGT_ABORT_SIG = 11;
	localparam int STS_DEVSEL_LO = 9;
	localparam int STS_MST_DPERR = 8;

	// ****************************************
	// fixed class codes
	// ****************************************
	localparam logic [7:0] PROG_IF_CODE = 8'h00;
	localparam logic [15:0] CLASS_CODE = 16'h0607;
endpackage : pcb_pkg

`default_nettype wire

//--- verilog/pcb_cfg_header.sv
/*
 * pcb_cfg_header: low configuration header of the card bridge (ids, command
 * word, status word, revision and class bytes) as an APB slave.
 * Assumes the bus engine beside it reports its events as one-cycle pulses
 * on pclk and honours the decode and master enables driven from here.
 */
// Operation
// - maker and part codes are fixed, read-only; writes change nothing.
// - command word resets to zero; bits 15 to 10 read as zero.
// - fast back-to-back enable bit 9 is tied to zero.
// - bit 8 set lets system errors drive the error pin; clear keeps it idle.
// - wait cycle control bit 7 reads zero and ignores writes.
// - bit 6 decides whether detected parity errors are signalled.
// - bits 5, 4, 3 tied to zero; special cycles ignored.
// - bit 2 allows starting transactions as master; else target only.
// - bit 1 clear means no memory transaction is claimed.
// - bit 0 clear means no I/O transaction is claimed.
// - status 15 sets on detected parity error; write one clears.
// - status 14 sets when system error is signalled; write one clears.
// - status 13 sets on master abort of own transaction; write one clears.
// - status 12 sets on received target abort; write one clears.
// - status 11 sets when we end a transfer with target abort.
// - status 10 to 9 read-only, medium select timing 01.
// - status 8 sets on data parity error while mastering; write one clears.
// - status 7 to 0 read zero; status resets to zero.
// - fixed read-only revision byte.
// - programming interface byte always reads 00.
// - class word reads 06 upper byte, 07 lower byte.
`timescale 1ns/1ps
`default_nettype none

module pcb_cfg_header
	import pcb_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'h5a5a, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'hc3c3, // arbitrary value
	parameter logic [7:0] REV_CODE = 8'h0a // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic par_err_seen,
	input wire logic sys_err_seen,
	input wire logic mst_abort_seen,
	input wire logic tgt_abort_rcvd,
	input wire logic tgt_abort_sent,
	input wire logic mst_data_par_err,
	input wire logic mem_hit,
	input wire logic io_hit,
	input wire logic master_req,
	output logic mem_claim,
	output logic io_claim,
	output logic master_go,
	output logic perr_out,
	output logic perr_oe_n,
	output logic serr_out,
	output logic serr_oe_n,
	output logic [1:0] devsel_timing
);

	// ****************************************
	// helpers
	// ****************************************

	// byte enables of the low half-word to a bit mask
	function automatic logic [15:0] lane_mask(input logic [STRB_W-1:0] strb);
		lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	// ****************************************
	// state
	// ****************************************
	logic [15:0] cmd_ff;
	logic [15:0] nxt_cmd;
	logic [15:0] sts_ff;
	logic [15:0] nxt_sts;
	logic [DATA_W-1:0] prdata_ff;
	logic serr_drive_ff;
	logic perr_drive_ff;

	// ****************************************
	// apb decode
	// ****************************************
	logic setup_ph;
	logic access_ph;
	logic wr_take;
	logic hit_maker;
	logic hit_part;
	logic hit_cmd;
	logic hit_sts;
	logic hit_rev;
	logic hit_prog;
	logic hit_class;
	logic addr_hit;
	logic [15:0] wmask;
	logic [15:0] sts_view;
	logic [DATA_W-1:0] rd_word;
	logic [15:0] sts_set;
	logic [15:0] sts_clr;

	// phase and address decode
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_take = access_ph & pwrite;
	assign hit_maker = (paddr == ADDR_MAKER);
	assign hit_part = (paddr == ADDR_PART);
	assign hit_cmd = (paddr == ADDR_CMD);
	assign hit_sts = (paddr == ADDR_STS);
	assign hit_rev = (paddr == ADDR_REV);
	assign hit_prog = (paddr == ADDR_PROG);
	assign hit_class = (paddr == ADDR_CLASS);
	assign addr_hit = hit_maker | hit_part | hit_cmd | hit_sts | hit_rev | hit_prog | hit_class;
	assign wmask = lane_mask(pstrb);

	// zero wait states; unmapped words answer with an error
	assign pready = access_ph;
	assign pslverr = access_ph & ~addr_hit;
	assign prdata = prdata_ff;

	// status as read: live flags plus fixed select timing
	assign sts_view = (sts_ff & STS_W1C_MASK) | {5'h00, DEVSEL_MEDIUM, 9'h000};

	// read mux; fixed codes are constants, never stored
	assign rd_word = hit_maker ? {16'h0000, MAKER_CODE} :
		hit_part ? {16'h0000, PART_CODE} :
		hit_cmd ? {16'h0000, cmd_ff} :
		hit_sts ? {16'h0000, sts_view} :
		hit_rev ? {24'h000000, REV_CODE} :
		hit_prog ? {24'h000000, PROG_IF_CODE} :
		hit_class ? {16'h0000, CLASS_CODE} :
		32'h00000000;

	// ****************************************
	// command word
	// ****************************************

	// only enabled lanes of writable bits change; others keep their value, read-only bits stay zero
	assign nxt_cmd = (wr_take & hit_cmd) ?
		((cmd_ff & ~(wmask & CMD_WR_MASK)) | (pwdata[15:0] & wmask & CMD_WR_MASK)) :
		(cmd_ff & CMD_WR_MASK);

	// decode and master enables
	assign mem_claim = mem_hit & cmd_ff[CMD_MEM_EN];
	assign io_claim = io_hit & cmd_ff[CMD_IO_EN];
	assign master_go = master_req & cmd_ff[CMD_MASTER_EN];
	assign devsel_timing = DEVSEL_MEDIUM;

	// ****************************************
	// status word
	// ****************************************

	// event sources of the sticky flags
	assign sts_set = {par_err_seen, serr_drive_ff, mst_abort_seen, tgt_abort_rcvd,
		tgt_abort_sent, 2'h0, mst_data_par_err, 8'h00};

	// write one clears, only in enabled lanes
	assign sts_clr = (wr_take & hit_sts) ? (pwdata[15:0] & wmask & STS_W1C_MASK) : 16'h0000;

	// a set in the clearing cycle wins
	assign nxt_sts = ((sts_ff & ~sts_clr) | sts_set) & STS_W1C_MASK;

	// ****************************************
	// error pins (open drain: drive low when flagged)
	// ****************************************
	assign serr_out = 1'b0;
	assign serr_oe_n = ~serr_drive_ff;
	assign perr_out = 1'b0;
	assign perr_oe_n = ~perr_drive_ff;

	// ****************************************
	// registers
	// ****************************************

	// configuration and status state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff <= CMD_RESET;
			sts_ff <= STS_RESET;
		end else begin
			cmd_ff <= nxt_cmd;
			sts_ff <= nxt_sts;
		end
	end

	// read data caught in setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (setup_ph) begin
			prdata_ff <= rd_word;
		end
	end

	// gated error signalling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serr_drive_ff <= 1'b0;
			perr_drive_ff <= 1'b0;
		end else begin
			serr_drive_ff <= sys_err_seen & cmd_ff[CMD_SERR_EN];
			perr_drive_ff <= par_err_seen & cmd_ff[CMD_PERR_EN];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rd_acc;
	assign rd_acc = access_ph & ~pwrite;

	AST_ID_FIXED: assert property (
		rd_acc && hit_part |-> prdata[15:0] == PART_CODE && prdata[31:16] == 16'h0000)
		else $error("part code read wrong");

	AST_CMD_HIGH_ZERO: assert property (
		wr_take && hit_cmd |=> cmd_ff[15:10] == 6'h00)
		else $error("command high bits not zero");

	AST_FBB_ZERO: assert property (
		rd_acc && hit_cmd |-> !prdata[CMD_FBB_EN])
		else $error("fast back-to-back bit read set");

	AST_SERR_GATED: assert property (
		sys_err_seen |=> (serr_oe_n == !$past(cmd_ff[CMD_SERR_EN])))
		else $error("error pin does not follow enable");

	AST_WAIT_ZERO: assert property (
		wr_take && hit_cmd && pwdata[CMD_WAIT_CTL] |=> !cmd_ff[CMD_WAIT_CTL])
		else $error("wait control bit stored");

	AST_PERR_GATED: assert property (
		!perr_oe_n |-> $past(par_err_seen) && $past(cmd_ff[CMD_PERR_EN]))
		else $error("parity error signalled without cause");

	AST_UNSUP_ZERO: assert property (
		rd_acc && hit_cmd |-> prdata[5:3] == 3'h0)
		else $error("unsupported command bits read set");

	AST_MASTER_GATE: assert property (
		master_go |-> cmd_ff[CMD_MASTER_EN] && master_req)
		else $error("master start while disabled");

	AST_MEM_GATE: assert property (
		mem_hit |-> mem_claim == cmd_ff[CMD_MEM_EN])
		else $error("memory claim mismatch");

	AST_IO_GATE: assert property (
		io_hit |-> io_claim == cmd_ff[CMD_IO_EN])
		else $error("io claim mismatch");

	AST_PAR_SET: assert property (
		par_err_seen |=> sts_ff[STS_PAR_ERR])
		else $error("parity flag not set");

	AST_PAR_HOLD: assert property (
		sts_ff[STS_PAR_ERR] && !sts_clr[STS_PAR_ERR] |=> sts_ff[STS_PAR_ERR])
		else $error("parity flag lost without write one");

	AST_SYS_SET: assert property (
		sys_err_seen && cmd_ff[CMD_SERR_EN] |=> ##1 sts_ff[STS_SYS_ERR])
		else $error("system error flag not set");

	AST_MST_ABORT: assert property (
		mst_abort_seen |=> sts_ff[STS_MST_ABORT])
		else $error("master abort flag not set");

	AST_TGT_RCV: assert property (
		tgt_abort_rcvd |=> sts_ff[STS_TGT_ABORT_RCV])
		else $error("received target abort flag not set");

	AST_TGT_SIG_CLR: assert property (
		sts_clr[STS_TGT_ABORT_SIG] && !tgt_abort_sent |=> !sts_ff[STS_TGT_ABORT_SIG])
		else $error("signalled target abort flag not cleared");

	AST_DEVSEL_READ: assert property (
		rd_acc && hit_sts |-> prdata[10:9] == DEVSEL_MEDIUM)
		else $error("select timing field wrong");

	AST_DPERR_SET: assert property (
		mst_data_par_err |=> sts_ff[STS_MST_DPERR])
		else $error("data parity flag not set");

	AST_STS_LOW_ZERO: assert property (
		rd_acc && hit_sts |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000)
		else $error("status low bits read set");

	AST_REV_READ: assert property (
		rd_acc && hit_rev |-> prdata == {24'h000000, REV_CODE})
		else $error("revision read wrong");

	AST_PROG_READ: assert property (
		rd_acc && hit_prog |-> prdata == 32'h00000000)
		else $error("programming interface not zero");

	AST_CLASS_READ: assert property (
		rd_acc && hit_class |-> prdata[15:8] == 8'h06 && prdata[7:0] == 8'h07)
		else $error("class word wrong");

	AST_LANE_KEEP: assert property (
		wr_take && hit_cmd && !pstrb[0] |=> cmd_ff[7:0] == $past(cmd_ff[7:0]))
		else $error("disabled byte lane written");

	AST_MAKER_FIXED: assert property (
		rd_acc && hit_maker |-> prdata == {16'h0000, MAKER_CODE})
		else $error("maker code read wrong");

	AST_UNMAPPED_QUIET: assert property (
		access_ph && !addr_hit |=> cmd_ff == $past(cmd_ff))
		else $error("unmapped access changed the command word");

	AST_RESET_CLEAR: assert property (
		$rose(presetn) |-> cmd_ff == CMD_RESET && sts_ff == STS_RESET)
		else $error("state not cleared by reset");

	// flags that must survive the next edge: set and not cleared now
	logic [15:0] sts_keep;
	assign sts_keep = sts_ff & ~sts_clr;

	AST_FLAGS_STICKY: assert property (
		sts_keep != 16'h0000 |=> (sts_ff & $past(sts_keep)) == $past(sts_keep))
		else $error("status flag lost without write one");

	COV_CMD_WRITE: cover property (wr_take && hit_cmd && pstrb[1:0] == 2'h3);
	COV_STS_CLEAR: cover property (sts_ff[STS_PAR_ERR] ##1 sts_clr[STS_PAR_ERR]);
	COV_SET_CLEAR_SAME: cover property (sts_clr[STS_MST_ABORT] && mst_abort_seen);
	COV_SERR_DRIVE: cover property (!serr_oe_n);
	COV_UNMAPPED: cover property (pslverr);

endmodule : pcb_cfg_header

`default_nettype wire

//--- sim/pcb_engine_model.sv
/*
 * pcb_engine_model: stand-in for the bus engine beside the header,
 * giving one-cycle event pulses and level hit requests.
 * Assumes the bench calls its tasks; all changes follow a pclk rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pcb_engine_model (
	input wire logic pclk,
	output logic [5:0] ev,
	output logic [2:0] hits
);
	// ****************************************
	// event and hit sources
	// ****************************************
	// idle: no events, no hits
	initial begin
		ev = 6'h00;
		hits = 3'h0;
	end

	// one event pulse, exactly one cycle wide
	task automatic fire(input int k);
		@(posedge pclk);
		ev[k] <= 1'b1;
		@(posedge pclk);
		ev <= 6'h00;
	endtask : fire

	// hit levels: {master request, io hit, memory hit}
	task automatic set_hits(input logic [2:0] h);
		@(posedge pclk);
		hits <= h;
	endtask : set_hits
endmodule : pcb_engine_model

`default_nettype wire

//--- sim/test_pcb_cfg_header.sv
/*
 * test_pcb_cfg_header: self-checking bench for the configuration header.
 * Assumes the header answers APB with zero wait states and the engine model
 * supplies its events.
 */
`timescale 1ns/1ps
`default_nettype none

module test_pcb_cfg_header;
	import pcb_pkg::*;
	localparam logic [15:0] MK = 16'h1b2c; // arbitrary value
	localparam logic [15:0] PT = 16'h3d4e; // arbitrary value
	localparam logic [7:0] RV = 8'h5f; // arbitrary value
	localparam logic [15:0] STS0 = 16'(DEVSEL_MEDIUM) << STS_DEVSEL_LO;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [STRB_W-1:0] pstrb = '0;
	wire logic [DATA_W-1:0] prdata;
	wire logic pready, pslverr, mem_claim, io_claim, master_go;
	wire logic perr_oe_n, serr_oe_n;
	wire logic perr_pin, serr_pin;
	wire logic [1:0] devsel;
	wire logic [5:0] ev;
	wire logic [2:0] hits;
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic er;
	logic [31:0] xs;
	int n;
	int flag_bit [6] = '{STS_PAR_ERR, STS_MST_ABORT, STS_TGT_ABORT_RCV,
		STS_TGT_ABORT_SIG, STS_MST_DPERR, STS_SYS_ERR};

	// ****************************************
	// clock, design and engine model
	// ****************************************
	always #50 pclk = ~pclk;

	pcb_cfg_header #(.MAKER_CODE(MK), .PART_CODE(PT), .REV_CODE(RV)) i_pcb_cfg_header (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.par_err_seen(ev[0]), .mst_abort_seen(ev[1]), .tgt_abort_rcvd(ev[2]),
		.tgt_abort_sent(ev[3]), .mst_data_par_err(ev[4]), .sys_err_seen(ev[5]),
		.mem_hit(hits[0]), .io_hit(hits[1]), .master_req(hits[2]),
		.mem_claim(mem_claim), .io_claim(io_claim), .master_go(master_go),
		.perr_out(perr_pin), .perr_oe_n(perr_oe_n), .serr_out(serr_pin),
		.serr_oe_n(serr_oe_n), .devsel_timing(devsel)
	);

	pcb_engine_model i_pcb_engine_model (.pclk(pclk), .ev(ev), .hits(hits));

	// ****************************************
	// checking and apb tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			fail_count++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one read, compared with its expected word
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
	endtask : rdc

	// event pulse, then count cycles with the error pin driven
	task automatic fire_cnt(input int k, input logic use_serr);
		n = 0;
		i_pcb_engine_model.fire(k);
		repeat (4) begin
			#1;
			if ((use_serr ? serr_oe_n : perr_oe_n) === 1'b0) n++;
			@(posedge pclk);
		end
	endtask : fire_cnt

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and fixed codes
		rdc(ADDR_MAKER, {16'h0, MK});
		rdc(ADDR_PART, {16'h0, PT});
		rdc(ADDR_CMD, {16'h0, CMD_RESET});
		rdc(ADDR_STS, {16'h0, STS0});
		rdc(ADDR_REV, {24'h0, RV});
		rdc(ADDR_PROG, 32'h0000_0000);
		rdc(ADDR_CLASS, 32'h0000_0607);
		rdc(12'h004, 32'h0000_0000);
		chk(er, 1'b1);
		chk(devsel, DEVSEL_MEDIUM);
		chk({serr_pin, perr_pin}, 2'h0);
		$display("test reset_values done");
		// writable bits, byte lanes, read-only words
		apb(1, ADDR_CMD, 32'hffff_ffff, 4'h3);
		rdc(ADDR_CMD, {16'h0, CMD_WR_MASK});
		apb(1, ADDR_CMD, 32'h0, 4'h2);
		rdc(ADDR_CMD, 32'h0000_0047);
		apb(1, 12'h011, 32'h0, 4'h3);
		chk(er, 1'b1);
		rdc(ADDR_CMD, 32'h0000_0047);
		apb(1, ADDR_MAKER, 32'hffff_ffff, 4'hf);
		rdc(ADDR_MAKER, {16'h0, MK});
		apb(1, ADDR_STS, 32'h0000_06ff, 4'h3);
		rdc(ADDR_STS, {16'h0, STS0});
		$display("test write_masks done");
		// decode and master enables
		i_pcb_engine_model.set_hits(3'h7);
		#1 chk({master_go, io_claim, mem_claim}, 3'h7);
		apb(1, ADDR_CMD, 32'h0, 4'h3);
		#1 chk({master_go, io_claim, mem_claim}, 3'h0);
		apb(1, ADDR_CMD, 32'h2, 4'h1);
		#1 chk({master_go, io_claim, mem_claim}, 3'h1);
		i_pcb_engine_model.set_hits(3'h0);
		$display("test enables done");
		// event flags and error pins, with reporting off then on
		for (int p = 0; p < 2; p++) begin
			apb(1, ADDR_CMD, p ? 32'h0140 : 32'h0, 4'h3);
			for (int k = 0; k < 6; k++) begin
				fire_cnt(k, k == 5);
				chk(n, (p == 1 && (k == 0 || k == 5)) ? 1 : 0);
				xs = {16'h0, STS0 | ((k == 5 && p == 0) ? 16'h0 : 16'h1 << flag_bit[k])};
				rdc(ADDR_STS, xs);
				apb(1, ADDR_STS, 32'h0, 4'h3);
				rdc(ADDR_STS, xs);
				apb(1, ADDR_STS, 32'h1 << flag_bit[k], 4'h3);
				rdc(ADDR_STS, {16'h0, STS0});
			end
		end
		$display("test status_flags done");
		// reset in mid-run clears command and flags
		i_pcb_engine_model.fire(1);
		rdc(ADDR_STS, {16'h0, STS0 | 16'h1 << STS_MST_ABORT});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_CMD, {16'h0, CMD_RESET});
		rdc(ADDR_STS, {16'h0, STS0});
		chk({serr_pin, perr_pin, serr_oe_n, perr_oe_n}, 4'h3);
		$display("test mid_reset done");
		final_report();
	end
endmodule : test_pcb_cfg_header

`default_nettype wire
